// File: rtl/upil_consts.vh
`ifndef UPIL_CONSTS_VH
`define UPIL_CONSTS_VH
`define UPIL_ADDR_LEVEL      6'h13
`define UPIL_ADDR_EVENT      6'h14
`define UPIL_BIT_HOST_DISC   0
`define UPIL_BIT_BUS_PWR     1
`define UPIL_BIT_SESS_OK     2
`define UPIL_BIT_SESS_END    3
`define UPIL_BIT_ID_GND      4
`define UPIL_NUM_SRC         5
`define UPIL_INIT_CYCLES     2'h3
`define UPIL_EDGE_EN_RESET   5'h1F
`define UPIL_ID_HOLD_MS      50
`define UPIL_CLK_MHZ         250
`define UPIL_ID_HOLD_CYCLES  (`UPIL_ID_HOLD_MS * 1000 * `UPIL_CLK_MHZ)
`endif

// File: rtl/upil_sync.v
`timescale 1ns/1ns
// two-flop synchroniser, one per bit
module upil_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rstn,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg s1_reg;
         reg s2_reg;
         always @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
            end else begin
               s1_reg <= d[i];
               s2_reg <= s1_reg;
            end
         end
         assign q[i] = s2_reg;
      end
   endgenerate
endmodule

// File: rtl/upil_top.v
// What this block does
// R1: status register at 0x13 shows live id, session end, session ok, power, disconnect.
// R2: id status bit frozen while id pull-up off and 50 ms after enabling.
// R3: session ok status is the same signal as the a-valid indication.
// R4: disconnect bit meaningful only in host mode; forced zero in low power.
// R5: after reset disconnect status reads the disconnect input in host mode, 0 outside host mode.
// R6: unmasked source change sets the matching bit of the latch register 0x14.
// R7: reading the latch register clears all its bits.
// R8: entering low power mode clears the latch register.
// R9: entering serial or carkit mode clears the latch, regardless of clock suspend.
// R10: event in the read-return cycle shows in returned latch data.
// R11: latch setting follows standard link interface rules for edges and masks.
// R12: link may skip reading latch in synchronous mode; reading stays optional.
// R13: disconnect latch host mode only; after reset takes the disconnect level in host mode, stays 0 otherwise.
// R14: host mode means both d+ and d- pull-down controls are set.
// R15: falling change counts only when its falling enable is 1; enables are input ports, not reset here.
// R16: id events masked while id pull-up off and 50 ms after enabling.
// R17: an event returned in clearing read data is not left latched.
`timescale 1ns/1ns
`include "upil_consts.vh"
module upil_top #(
   parameter ID_HOLD_CYCLES = `UPIL_ID_HOLD_CYCLES
) (
   input  wire       CORE_CLK,
   input  wire       RSTN,
   input  wire       ID_GROUNDED_IN,
   input  wire       SESSION_ENDED_IN,
   input  wire       SESSION_OK_IN,
   input  wire       BUS_POWER_OK_IN,
   input  wire       HOST_DISCONNECT_IN,
   input  wire       ID_PULLUP,
   input  wire       DP_PULLDOWN,
   input  wire       DM_PULLDOWN,
   input  wire       LOW_POWER_MODE,
   input  wire       SERIAL_MODE,
   input  wire       CARKIT_MODE,
   input  wire       CLOCK_SUSPEND,
   input  wire [4:0] RISE_ENABLE,
   input  wire [4:0] FALL_ENABLE,
   input  wire       REG_READ,
   input  wire [5:0] REG_ADDR,
   output reg  [7:0] REG_RDATA,
   output reg        REG_RVALID,
   output wire       SESSION_OK_AVALID,
   output wire [4:0] EVENT_PULSE
);
   localparam CW = 24; // holds the default hold count

   wire [4:0] src_sync;
   reg  [4:0] level_reg;
   reg  [4:0] event_reg;
   reg  [4:0] event_next;
   reg  [CW-1:0] id_cnt_reg;
   reg        id_pu_prev_reg;
   reg  [1:0] init_cnt_reg;
   reg        lp_prev_reg;
   reg        ser_prev_reg;
   reg        ck_prev_reg;
   reg  [4:0] live_level;
   reg  [4:0] src_mask;
   wire       host_mode;
   wire       id_masked;
   wire       lp_entry;
   wire       mode_entry;
   wire [4:0] rise;
   wire [4:0] fall;
   wire [4:0] unmasked_evt;
   wire [4:0] edge_evt;
   wire [4:0] init_evt;
   wire       init_busy;
   wire       init_last;
   wire       rd_level;
   wire       rd_event;

   upil_sync #(.W(5)) u_sync (
      .clk  (CORE_CLK),
      .rstn (RSTN),
      .d    ({ID_GROUNDED_IN, SESSION_ENDED_IN, SESSION_OK_IN, BUS_POWER_OK_IN, HOST_DISCONNECT_IN}),
      .q    (src_sync)
   );

   assign host_mode = DP_PULLDOWN & DM_PULLDOWN; // R14

   // id masking window: pull-up off, or hold counter still running
   always @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         id_cnt_reg     <= {CW{1'b0}};
         id_pu_prev_reg <= 1'b0;
      end else begin
         id_pu_prev_reg <= ID_PULLUP;
         if (!ID_PULLUP)
            id_cnt_reg <= {CW{1'b0}};
         else if (!id_pu_prev_reg)
            id_cnt_reg <= ID_HOLD_CYCLES[CW-1:0];
         else if (id_cnt_reg != {CW{1'b0}})
            id_cnt_reg <= id_cnt_reg - {{(CW-1){1'b0}}, 1'b1};
      end
   end
   assign id_masked = !ID_PULLUP || !id_pu_prev_reg || (id_cnt_reg != {CW{1'b0}}); // R2 R16

   always @* begin
      live_level = src_sync;
      live_level[`UPIL_BIT_ID_GND] = id_masked ? level_reg[`UPIL_BIT_ID_GND]
                                               : src_sync[`UPIL_BIT_ID_GND]; // R2
      live_level[`UPIL_BIT_HOST_DISC] = src_sync[`UPIL_BIT_HOST_DISC] & host_mode
                                        & !LOW_POWER_MODE; // R4
      src_mask = 5'h1F;
      src_mask[`UPIL_BIT_ID_GND] = !id_masked; // R16
      src_mask[`UPIL_BIT_HOST_DISC] = host_mode; // R13
   end

   assign SESSION_OK_AVALID = level_reg[`UPIL_BIT_SESS_OK]; // R3

   assign rise = live_level & ~level_reg;
   assign fall = ~live_level & level_reg;
   assign init_busy    = (init_cnt_reg != 2'h0);
   assign init_last    = (init_cnt_reg == 2'h1);
   assign edge_evt     = ((rise & RISE_ENABLE) | (fall & FALL_ENABLE)) & src_mask; // R6 R11 R15
   // no edges count while the synchroniser fills; the disconnect latch then takes its level
   assign init_evt     = {4'h0, init_last & live_level[`UPIL_BIT_HOST_DISC]}; // R5 R13
   assign unmasked_evt = init_busy ? init_evt : edge_evt;
   assign EVENT_PULSE = unmasked_evt;

   assign lp_entry   = LOW_POWER_MODE & !lp_prev_reg;
   assign mode_entry = (SERIAL_MODE & !ser_prev_reg) | (CARKIT_MODE & !ck_prev_reg); // R9

   assign rd_level = REG_READ && (REG_ADDR == `UPIL_ADDR_LEVEL);
   assign rd_event = REG_READ && (REG_ADDR == `UPIL_ADDR_EVENT);

   always @* begin
      event_next = event_reg | unmasked_evt; // R6
      if (rd_event)
         event_next = 5'h00; // R7 R17
      if (lp_entry)
         event_next = 5'h00; // R8
      if (mode_entry)
         event_next = 5'h00; // R9
   end

   always @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         level_reg    <= 5'h00;
         event_reg    <= 5'h00;
         init_cnt_reg <= `UPIL_INIT_CYCLES;
         lp_prev_reg  <= 1'b0;
         ser_prev_reg <= 1'b0;
         ck_prev_reg  <= 1'b0;
         REG_RDATA    <= 8'h00;
         REG_RVALID   <= 1'b0;
      end else begin
         lp_prev_reg  <= LOW_POWER_MODE;
         ser_prev_reg <= SERIAL_MODE;
         ck_prev_reg  <= CARKIT_MODE;
         level_reg    <= live_level; // R1
         event_reg    <= event_next;
         if (init_busy)
            init_cnt_reg <= init_cnt_reg - 2'h1;
         REG_RVALID <= REG_READ;
         // status comes from the same flop as the a-valid output
         if (rd_level)
            REG_RDATA <= {3'h0, level_reg}; // R1 R3
         else if (rd_event)
            REG_RDATA <= {3'h0, event_reg | unmasked_evt}; // R10 R17
         else if (REG_READ)
            REG_RDATA <= 8'h00;
      end
   end
endmodule

// File: dv/upil_checker.sv
`timescale 1ns/1ns
module upil_checker (
   input wire       CORE_CLK,
   input wire       RSTN,
   input wire       LOW_POWER_MODE,
   input wire       SERIAL_MODE,
   input wire       CARKIT_MODE,
   input wire       REG_READ,
   input wire       REG_RVALID,
   input wire       SESSION_OK_AVALID,
   input wire [5:0] REG_ADDR,
   input wire [7:0] REG_RDATA,
   input wire [4:0] EVENT_PULSE
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);
   wire ev = REG_READ && REG_ADDR == 6'h14;
   wire lv = REG_READ && REG_ADDR == 6'h13;
   wire q = EVENT_PULSE == 5'h00;
   // quiet run-up, then a latch read two cycles after a clearing entry
   sequence s_rd; q ##1 q ##1 (ev && q); endsequence
   property p_ans; REG_READ |=> REG_RVALID; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_rsv; REG_RVALID |-> REG_RDATA[7:5] == 3'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved set");
   property p_avl; lv |=> REG_RDATA[2] == $past(SESSION_OK_AVALID); endproperty
   a_avl: assert property (p_avl) else $error("avalid differs");
   property p_dsc; LOW_POWER_MODE [*3] ##0 lv |=> REG_RDATA[0] == 1'h0; endproperty
   a_dsc: assert property (p_dsc) else $error("disconnect set");
   property p_evt; ev |=> (REG_RDATA[4:0] & $past(EVENT_PULSE)) == $past(EVENT_PULSE); endproperty
   a_evt: assert property (p_evt) else $error("event lost");
   property p_one; ev ##1 (ev && q) |=> REG_RDATA == 8'h00; endproperty
   a_one: assert property (p_one) else $error("event kept");
   property p_lpc; $rose(LOW_POWER_MODE) ##0 s_rd |=> REG_RDATA == 8'h00; endproperty
   a_lpc: assert property (p_lpc) else $error("no clear");
   property p_mod; $rose(SERIAL_MODE || CARKIT_MODE) ##0 s_rd |=> REG_RDATA == 8'h00; endproperty
   a_mod: assert property (p_mod) else $error("no clear");
   cover property (ev && !q);
   cover property ($rose(LOW_POWER_MODE));
   cover property ($rose(CARKIT_MODE));
endmodule

// File: dv/upil_link_model.sv
`timescale 1ns/1ns
module upil_link_model (
   input wire         CORE_CLK,
   input wire         REG_RVALID,
   input wire  [7:0]  REG_RDATA,
   output logic       REG_READ = '0,
   output logic [5:0] REG_ADDR = '0
);
   task rd(input [5:0] a, input int n, output logic [7:0] d, output logic ok);
      @(negedge CORE_CLK);
      REG_READ = '1;
      REG_ADDR = a;
      repeat (n) @(negedge CORE_CLK);
      REG_READ = '0;
      REG_ADDR = ~a;
      ok = REG_RVALID;
      d = REG_RDATA;
   endtask
endmodule

// File: dv/upil_top_tb.sv
`timescale 1ns/1ns
module upil_top_tb;
   logic CORE_CLK = '0, RSTN = '0, ID_PULLUP = '0, DP_PULLDOWN = '1, DM_PULLDOWN = '1, CLOCK_SUSPEND = '0;
   logic LOW_POWER_MODE = '0, SERIAL_MODE = '0, CARKIT_MODE = '0, REG_READ, REG_RVALID, SESSION_OK_AVALID, ok;
   logic [4:0] src = 5'h01, RISE_ENABLE = 5'h1F, FALL_ENABLE = 5'h1F, EVENT_PULSE;
   logic [5:0] REG_ADDR;
   logic [7:0] REG_RDATA, d;
   int bad_count = 0, samples_checked = 0;
   always #2 CORE_CLK = ~CORE_CLK;
   upil_top #(.ID_HOLD_CYCLES(20)) i_upil_top (
      .CORE_CLK           (CORE_CLK),
      .RSTN               (RSTN),
      .ID_GROUNDED_IN     (src[4]),
      .SESSION_ENDED_IN   (src[3]),
      .SESSION_OK_IN      (src[2]),
      .BUS_POWER_OK_IN    (src[1]),
      .HOST_DISCONNECT_IN (src[0]),
      .ID_PULLUP          (ID_PULLUP),
      .DP_PULLDOWN        (DP_PULLDOWN),
      .DM_PULLDOWN        (DM_PULLDOWN),
      .LOW_POWER_MODE     (LOW_POWER_MODE),
      .SERIAL_MODE        (SERIAL_MODE),
      .CARKIT_MODE        (CARKIT_MODE),
      .CLOCK_SUSPEND      (CLOCK_SUSPEND),
      .RISE_ENABLE        (RISE_ENABLE),
      .FALL_ENABLE        (FALL_ENABLE),
      .REG_READ           (REG_READ),
      .REG_ADDR           (REG_ADDR),
      .REG_RDATA          (REG_RDATA),
      .REG_RVALID         (REG_RVALID),
      .SESSION_OK_AVALID  (SESSION_OK_AVALID),
      .EVENT_PULSE        (EVENT_PULSE)
   );
   upil_link_model i_upil_link_model (
      .CORE_CLK   (CORE_CLK),
      .REG_RVALID (REG_RVALID),
      .REG_RDATA  (REG_RDATA),
      .REG_READ   (REG_READ),
      .REG_ADDR   (REG_ADDR)
   );
   task wt(input int n); repeat (n) @(negedge CORE_CLK); endtask
   task rd(input [5:0] a, input int n); i_upil_link_model.rd(a, n, d, ok); endtask
   task chk(input [5:0] a, input [7:0] e, input int n = 1);
      rd(a, n);
      samples_checked++;
      if (d !== e || ok !== 1'h1) begin
         bad_count++;
         $display("mismatch reg %h exp %h got %h", a, e, d);
      end
   endtask
   task chk_pin(input string nm, input [4:0] e, input [4:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task test_done;
      if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task s_reset;
      chk(6'h13, 8'h01);
      chk(6'h14, 8'h01);
      chk(6'h14, 8'h00);
      DP_PULLDOWN = '0; wt(3); chk(6'h13, 8'h00);
      DP_PULLDOWN = '1; wt(3); rd(6'h14, 2);
   endtask
   task s_live;
      src = 5'h1F; wt(5);
      chk(6'h13, 8'h0F);
      chk(6'h14, 8'h0E);
      chk_pin("avalid", 5'h01, {4'h0, SESSION_OK_AVALID});
      ID_PULLUP = '1; wt(24);
      chk(6'h13, 8'h1F);
      rd(6'h14, 2);
   endtask
   task s_fall;
      FALL_ENABLE = 5'h1D; src = 5'h19; wt(2);
      chk_pin("event pulse", 5'h04, EVENT_PULSE);
      wt(3);
      chk_pin("avalid", 5'h00, {4'h0, SESSION_OK_AVALID});
      chk(6'h14, 8'h04);
   endtask
   task s_lp;
      FALL_ENABLE = 5'h1E; src = 5'h11; wt(5);
      LOW_POWER_MODE = '1; wt(1);
      chk(6'h14, 8'h00);
      chk(6'h13, 8'h10);
      LOW_POWER_MODE = '0; wt(4); rd(6'h14, 2);
      FALL_ENABLE = 5'h1F;
   endtask
   task s_mode;
      for (int i = 0; i < 2; i++) begin
         src[1] = ~src[1]; CLOCK_SUSPEND = i[0]; wt(5);
         {CARKIT_MODE, SERIAL_MODE} = 2'h1 << i; wt(1);
         chk(6'h14, 8'h00);
         {CARKIT_MODE, SERIAL_MODE} = 2'h0; wt(2);
      end
   endtask
   task s_b2b;
      src[2] = '1; chk(6'h14, 8'h04, 2);
      rd(6'h14, 8);
      chk(6'h14, 8'h00);
      chk(6'h15, 8'h00);
   endtask
   initial begin
      wt(5); RSTN = '1; wt(4);
      s_reset; s_live; s_fall; s_lp; s_mode; s_b2b;
      test_done;
   end
endmodule
bind upil_top upil_checker i_upil_checker (
   .CORE_CLK          (CORE_CLK),
   .RSTN              (RSTN),
   .LOW_POWER_MODE    (LOW_POWER_MODE),
   .SERIAL_MODE       (SERIAL_MODE),
   .CARKIT_MODE       (CARKIT_MODE),
   .REG_READ          (REG_READ),
   .REG_RVALID        (REG_RVALID),
   .SESSION_OK_AVALID (SESSION_OK_AVALID),
   .REG_ADDR          (REG_ADDR),
   .REG_RDATA         (REG_RDATA),
   .EVENT_PULSE       (EVENT_PULSE)
);
